// >>> rtl/fliu_top.sv
// Purpose: Interrupt service unit: flags, enables, priority, vector to CPU.
// Assumes: CPU pulses vec_ack when it takes the vector, ret_pulse on return.
// Notes: Timer and serial logic sit outside and feed pulses or flag levels.
`timescale 1ns/1ps
`default_nettype none
module fliu_top (
	input wire logic clk_sys,
	input wire logic nrst,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// External pins, asynchronous.
	input wire logic ext_pin_zero,
	input wire logic ext_pin_one,
	// Timer overflow pulses and serial flag levels.
	input wire logic timer_zero_ovf,
	input wire logic timer_one_ovf,
	input wire logic serial_tx_done_flag,
	input wire logic serial_rx_done_flag,
	// Level request pins from peripheral logic on this clock.
	input wire logic level_irq_a,
	input wire logic level_irq_b,
	input wire logic level_irq_c,
	input wire logic level_irq_d,
	input wire logic level_irq_e,
	input wire logic level_irq_f,
	input wire logic level_irq_g,
	input wire logic level_irq_h,
	// CPU sequencer side.
	input wire logic vec_ack,
	input wire logic ret_pulse,
	output logic irq_req,
	output logic [15:0] irq_vector
);
	import fliu_pkg::*;
	// ==========================================================
	// Registers and state.
	logic [7:0] en_primary_ff; // Primary enable register.
	logic [7:0] en_extra_ff; // Level pin enable register.
	logic [5:0] prio_low_ff; // Low priority bits.
	logic [5:0] prio_high_ff; // High priority bits.
	logic ext_zero_type_sel_ff; // One selects falling edge.
	logic ext_one_type_sel_ff; // One selects falling edge.
	logic ext_zero_req_flag_ff; // External zero flag.
	logic ext_one_req_flag_ff; // External one flag.
	logic timer_zero_ovf_flag_ff; // Timer zero flag.
	logic timer_one_ovf_flag_ff; // Timer one flag.
	logic [3:0] in_service_ff; // One bit per level being serviced.
	logic irq_req_ff; // Request to the CPU.
	logic [3:0] req_src_ff; // Source being presented.
	logic [1:0] req_lvl_ff; // Its level.
	logic [15:0] vector_ff; // Its vector.
	logic [7:0] rdata_ff; // Read data.
	logic [3:0] mcyc_cnt_ff; // Machine cycle divider.
	logic mcyc_en; // One pulse per machine cycle.
	logic x0_low, x0_fall, x1_low, x1_fall; // Pin detector results.
	logic [FLIU_NUM_SRC-1:0] raw_req; // Requests before enables.
	logic [FLIU_NUM_SRC-1:0] gated_req; // Requests after enables.
	logic win_valid;
	logic [3:0] win_src;
	logic [1:0] win_lvl;
	logic can_preempt; // Winner beats the running routine.
	logic taken; // CPU takes the presented vector this cycle.
	logic wr_ctrl; // Write to the external control register.
	logic [3:0] nxt_in_service; // Next in-service set.
	// ==========================================================
	// Machine cycle enable divider.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			mcyc_cnt_ff <= 4'h0;
		end else if (mcyc_cnt_ff == 4'(FLIU_MCYC_CLKS - 1)) begin
			mcyc_cnt_ff <= 4'h0;
		end else begin
			mcyc_cnt_ff <= mcyc_cnt_ff + 4'h1;
		end
	end
	assign mcyc_en = (mcyc_cnt_ff == 4'(FLIU_MCYC_CLKS - 1));
	// ==========================================================
	// Pin detectors for the two classic external pins.
	fliu_pin_detect u_pin_zero (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.mcyc_en(mcyc_en),
		.pin(ext_pin_zero),
		.pin_low(x0_low),
		.fall_pulse(x0_fall)
	);
	fliu_pin_detect u_pin_one (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.mcyc_en(mcyc_en),
		.pin(ext_pin_one),
		.pin_low(x1_low),
		.fall_pulse(x1_fall)
	);
	// ==========================================================
	// Register writes.
	assign wr_ctrl = reg_wr && reg_addr == FLIU_OFS_EXT_CTRL;
	assign taken = irq_req_ff && vec_ack;
	// Enable and priority registers.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			en_primary_ff <= FLIU_RST_EN;
			en_extra_ff <= FLIU_RST_EN;
			prio_low_ff <= FLIU_RST_PRIO;
			prio_high_ff <= FLIU_RST_PRIO;
		end else if (reg_wr) begin
			// Unused bits of the primary register never store.
			if (reg_addr == FLIU_OFS_EN_PRIMARY) begin
				en_primary_ff <= reg_wdata & FLIU_EN_PRIMARY_MASK;
			end
			if (reg_addr == FLIU_OFS_EN_EXTRA) begin
				en_extra_ff <= reg_wdata;
			end
			if (reg_addr == FLIU_OFS_PRIO_LOW) begin
				prio_low_ff <= reg_wdata[5:0];
			end
			if (reg_addr == FLIU_OFS_PRIO_HIGH) begin
				prio_high_ff <= reg_wdata[5:0];
			end
		end
	end
	// Type selection bits.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ext_zero_type_sel_ff <= 1'b0;
			ext_one_type_sel_ff <= 1'b0;
		end else if (wr_ctrl) begin
			ext_zero_type_sel_ff <= reg_wdata[FLIU_BIT_XT0];
			ext_one_type_sel_ff <= reg_wdata[FLIU_BIT_XT1];
		end
	end
	// ==========================================================
	// External flags: edge mode latches, level mode follows the pin.
	// A new edge in the same cycle as a clear keeps the flag set.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ext_zero_req_flag_ff <= 1'b0;
			ext_one_req_flag_ff <= 1'b0;
		end else begin
			if (!ext_zero_type_sel_ff) begin
				ext_zero_req_flag_ff <= x0_low;
			end else if (x0_fall) begin
				ext_zero_req_flag_ff <= 1'b1;
			end else if (taken && req_src_ff == FLIU_SRC_X0) begin
				ext_zero_req_flag_ff <= 1'b0;
			end else if (wr_ctrl) begin
				ext_zero_req_flag_ff <= reg_wdata[FLIU_BIT_XF0];
			end
			if (!ext_one_type_sel_ff) begin
				ext_one_req_flag_ff <= x1_low;
			end else if (x1_fall) begin
				ext_one_req_flag_ff <= 1'b1;
			end else if (taken && req_src_ff == FLIU_SRC_X1) begin
				ext_one_req_flag_ff <= 1'b0;
			end else if (wr_ctrl) begin
				ext_one_req_flag_ff <= reg_wdata[FLIU_BIT_XF1];
			end
		end
	end
	// ==========================================================
	// Timer flags: set by overflow, cleared by vectoring or software.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			timer_zero_ovf_flag_ff <= 1'b0;
			timer_one_ovf_flag_ff <= 1'b0;
		end else begin
			if (timer_zero_ovf) begin
				timer_zero_ovf_flag_ff <= 1'b1;
			end else if (taken && req_src_ff == FLIU_SRC_T0) begin
				timer_zero_ovf_flag_ff <= 1'b0;
			end else if (wr_ctrl) begin
				timer_zero_ovf_flag_ff <= reg_wdata[FLIU_BIT_TF0];
			end
			if (timer_one_ovf) begin
				timer_one_ovf_flag_ff <= 1'b1;
			end else if (taken && req_src_ff == FLIU_SRC_T1) begin
				timer_one_ovf_flag_ff <= 1'b0;
			end else if (wr_ctrl) begin
				timer_one_ovf_flag_ff <= reg_wdata[FLIU_BIT_TF1];
			end
		end
	end
	// ==========================================================
	// Request gathering; serial flags are only read, never cleared here.
	always_comb begin
		raw_req = '0;
		raw_req[FLIU_SRC_X0] = ext_zero_req_flag_ff;
		raw_req[FLIU_SRC_LA] = level_irq_a;
		raw_req[FLIU_SRC_LB] = level_irq_b;
		raw_req[FLIU_SRC_T0] = timer_zero_ovf_flag_ff;
		raw_req[FLIU_SRC_LC] = level_irq_c;
		raw_req[FLIU_SRC_X1] = ext_one_req_flag_ff;
		raw_req[FLIU_SRC_LD] = level_irq_d;
		raw_req[FLIU_SRC_T1] = timer_one_ovf_flag_ff;
		raw_req[FLIU_SRC_LE] = level_irq_e;
		raw_req[FLIU_SRC_SER] = serial_tx_done_flag | serial_rx_done_flag;
		raw_req[FLIU_SRC_LF] = level_irq_f;
		raw_req[FLIU_SRC_LG] = level_irq_g;
		raw_req[FLIU_SRC_LH] = level_irq_h;
	end
	// Per-source enables, then the global enable over all.
	always_comb begin
		gated_req = raw_req;
		gated_req[FLIU_SRC_X0] = raw_req[FLIU_SRC_X0] & en_primary_ff[FLIU_BIT_X0_EN];
		gated_req[FLIU_SRC_T0] = raw_req[FLIU_SRC_T0] & en_primary_ff[FLIU_BIT_T0_EN];
		gated_req[FLIU_SRC_X1] = raw_req[FLIU_SRC_X1] & en_primary_ff[FLIU_BIT_X1_EN];
		gated_req[FLIU_SRC_T1] = raw_req[FLIU_SRC_T1] & en_primary_ff[FLIU_BIT_T1_EN];
		gated_req[FLIU_SRC_SER] = raw_req[FLIU_SRC_SER] & en_primary_ff[FLIU_BIT_SERIAL_EN];
		gated_req[FLIU_SRC_LA] = raw_req[FLIU_SRC_LA] & en_extra_ff[0];
		gated_req[FLIU_SRC_LB] = raw_req[FLIU_SRC_LB] & en_extra_ff[1];
		gated_req[FLIU_SRC_LC] = raw_req[FLIU_SRC_LC] & en_extra_ff[2];
		gated_req[FLIU_SRC_LD] = raw_req[FLIU_SRC_LD] & en_extra_ff[3];
		gated_req[FLIU_SRC_LE] = raw_req[FLIU_SRC_LE] & en_extra_ff[4];
		gated_req[FLIU_SRC_LF] = raw_req[FLIU_SRC_LF] & en_extra_ff[5];
		gated_req[FLIU_SRC_LG] = raw_req[FLIU_SRC_LG] & en_extra_ff[6];
		gated_req[FLIU_SRC_LH] = raw_req[FLIU_SRC_LH] & en_extra_ff[7];
		if (!en_primary_ff[FLIU_BIT_GLOBAL_EN]) begin
			gated_req = '0;
		end
	end
	// ==========================================================
	// Arbitration across the four levels.
	fliu_arbiter u_arb (
		.req(gated_req),
		.prio_low(prio_low_ff),
		.prio_high(prio_high_ff),
		.win_valid(win_valid),
		.win_src(win_src),
		.win_lvl(win_lvl)
	);
	// Winner must be strictly above every level now in service.
	always_comb begin
		can_preempt = 1'b1;
		for (int l = 0; l < FLIU_NUM_LVL; l++) begin
			if (in_service_ff[l] && win_lvl <= 2'(l)) begin
				can_preempt = 1'b0;
			end
		end
	end
	// ==========================================================
	// Request and vector to the CPU; dropped for one cycle after each take.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			irq_req_ff <= 1'b0;
			req_src_ff <= 4'h0;
			req_lvl_ff <= 2'h0;
			vector_ff <= 16'h0000;
		end else begin
			irq_req_ff <= win_valid && can_preempt && !taken;
			req_src_ff <= win_src;
			req_lvl_ff <= win_lvl;
			vector_ff <= fliu_vector(win_src);
		end
	end
	// In-service levels: return clears the highest, take sets its level.
	// Popping first lets a return and a take in one cycle keep the new level.
	always_comb begin
		nxt_in_service = in_service_ff;
		if (ret_pulse) begin
			if (in_service_ff[3]) begin
				nxt_in_service[3] = 1'b0;
			end else if (in_service_ff[2]) begin
				nxt_in_service[2] = 1'b0;
			end else if (in_service_ff[1]) begin
				nxt_in_service[1] = 1'b0;
			end else begin
				nxt_in_service[0] = 1'b0;
			end
		end
		if (taken) begin
			nxt_in_service[req_lvl_ff] = 1'b1;
		end
	end
	// In-service register.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			in_service_ff <= 4'h0;
		end else begin
			in_service_ff <= nxt_in_service;
		end
	end
	assign irq_req = irq_req_ff;
	assign irq_vector = vector_ff;
	// ==========================================================
	// Read data one cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			rdata_ff <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				FLIU_OFS_EN_PRIMARY: rdata_ff <= en_primary_ff;
				FLIU_OFS_EN_EXTRA: rdata_ff <= en_extra_ff;
				FLIU_OFS_PRIO_LOW: rdata_ff <= {2'b00, prio_low_ff};
				FLIU_OFS_PRIO_HIGH: rdata_ff <= {2'b00, prio_high_ff};
				FLIU_OFS_EXT_CTRL: rdata_ff <= {timer_one_ovf_flag_ff, 1'b0,
					timer_zero_ovf_flag_ff, 1'b0, ext_one_req_flag_ff,
					ext_one_type_sel_ff, ext_zero_req_flag_ff, ext_zero_type_sel_ff};
				FLIU_OFS_STATUS: rdata_ff <= {3'b000, irq_req_ff, in_service_ff};
				default: rdata_ff <= 8'h00;
			endcase
		end else begin
			rdata_ff <= 8'h00;
		end
	end
	assign reg_rdata = rdata_ff;
	// ==========================================================
	// Checks.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence s_take;
		irq_req_ff && vec_ack;
	endsequence
	a_global_mask: assert property (!en_primary_ff[FLIU_BIT_GLOBAL_EN] |=> !irq_req_ff)
		else $error("Request raised with global enable off.");
	a_edge_clear: assert property (s_take and req_src_ff == FLIU_SRC_X0 && ext_zero_type_sel_ff
		&& !x0_fall |=> !ext_zero_req_flag_ff)
		else $error("Edge flag not cleared on vectoring.");
	a_level_follow: assert property (!ext_zero_type_sel_ff && !$past(wr_ctrl)
		|-> ext_zero_req_flag_ff == $past(x0_low))
		else $error("Level flag not following pin.");
	a_edge_set: assert property (ext_one_type_sel_ff && x1_fall |=> ext_one_req_flag_ff)
		else $error("Edge event lost.");
	a_timer_clear: assert property (s_take and req_src_ff == FLIU_SRC_T1 && !timer_one_ovf
		|=> !timer_one_ovf_flag_ff)
		else $error("Timer flag not cleared on vectoring.");
	a_serial_vector: assert property (irq_req_ff && req_src_ff == FLIU_SRC_SER
		|-> irq_vector == 16'h0023)
		else $error("Serial vector wrong.");
	a_level_vector: assert property (irq_req_ff && req_src_ff == FLIU_SRC_LA
		|-> irq_vector == 16'h0083)
		else $error("Level pin a vector wrong.");
	a_no_preempt: assert property (irq_req_ff |-> (in_service_ff >> req_lvl_ff) == 4'h0)
		else $error("Request not above running level.");
	a_tie_order: assert property (win_valid && gated_req[FLIU_SRC_X0]
		&& win_lvl == {prio_high_ff[0], prio_low_ff[0]} |-> win_src == FLIU_SRC_X0)
		else $error("Polling order broken.");
	a_enable_gate: assert property (!en_extra_ff[7] |-> !gated_req[FLIU_SRC_LH])
		else $error("Masked source passed.");
	a_take_gap: assert property (s_take |=> !irq_req_ff ##1 1'b1)
		else $error("Request not dropped after take.");
endmodule
`default_nettype wire

// >>> rtl/fliu_pkg.sv
// Purpose: Shared constants for the four level interrupt unit.
// Assumes: Byte-wide register port, one core clock of 200 MHz.
// Notes: Source numbers follow the fixed polling order, lowest number wins ties.
// What this block does
// - Thirteen sources, four levels, one request out.
// - Type bit picks falling edge or low level.
// - External event sets flag; enable gates it.
// - Edge mode flag cleared on vectoring.
// - Level mode flag follows pin, not cleared.
// - Timer flags request; cleared when vectored.
// - Serial request is transmit OR receive flag.
// - Serial flags never cleared by vectoring.
// - Each request gated by its own enable.
// - Primary enable: global, serial, timers, externals.
// - Extra enable: one bit per level pin.
// - Two priority bits give level zero to three.
// - Six priority pairs govern fixed source groups.
// - Equal level ties follow fixed polling order.
// - Standard sources use their fixed vectors.
// - Level pin sources use their fixed vectors.
// - Level pins active high, no capture latch.
package fliu_pkg;
	// ==========================================================
	// Register offsets.
	localparam logic [7:0] FLIU_OFS_EN_PRIMARY = 8'h00; // Primary enable register.
	localparam logic [7:0] FLIU_OFS_EN_EXTRA = 8'h01; // Level pin enable register.
	localparam logic [7:0] FLIU_OFS_PRIO_LOW = 8'h02; // Low priority bits.
	localparam logic [7:0] FLIU_OFS_PRIO_HIGH = 8'h03; // High priority bits.
	localparam logic [7:0] FLIU_OFS_EXT_CTRL = 8'h04; // Type bits and flags.
	localparam logic [7:0] FLIU_OFS_STATUS = 8'h05; // In-service and request state.
	// ==========================================================
	// Field positions.
	localparam int FLIU_BIT_GLOBAL_EN = 7; // Global enable in primary register.
	localparam int FLIU_BIT_SERIAL_EN = 4; // Serial enable.
	localparam int FLIU_BIT_T1_EN = 3; // Timer one enable.
	localparam int FLIU_BIT_X1_EN = 2; // External one enable.
	localparam int FLIU_BIT_T0_EN = 1; // Timer zero enable.
	localparam int FLIU_BIT_X0_EN = 0; // External zero enable.
	localparam int FLIU_BIT_TF1 = 7; // Timer one flag in control register.
	localparam int FLIU_BIT_TF0 = 5; // Timer zero flag.
	localparam int FLIU_BIT_XF1 = 3; // External one flag.
	localparam int FLIU_BIT_XT1 = 2; // External one type bit.
	localparam int FLIU_BIT_XF0 = 1; // External zero flag.
	localparam int FLIU_BIT_XT0 = 0; // External zero type bit.
	localparam logic [7:0] FLIU_EN_PRIMARY_MASK = 8'h9f; // Bits 6 and 5 read as zero.
	localparam logic [7:0] FLIU_PRIO_MASK = 8'h3f; // Bits 7 and 6 read as zero.
	// ==========================================================
	// Reset values.
	localparam logic [7:0] FLIU_RST_EN = 8'h00; // All sources masked.
	localparam logic [5:0] FLIU_RST_PRIO = 6'h00; // All groups at level zero.
	// ==========================================================
	// Sizes and timing.
	localparam int FLIU_NUM_SRC = 13; // Number of sources.
	localparam int FLIU_NUM_LVL = 4; // Number of priority levels.
	localparam real FLIU_MCYC_NS = 60.0; // One machine cycle in ns.
	localparam real FLIU_CLK_NS = 5.0; // Core clock period in ns.
	localparam int FLIU_MCYC_CLKS = int'(FLIU_MCYC_NS / FLIU_CLK_NS); // Clocks per cycle.
	// ==========================================================
	// Source numbers in polling order.
	typedef enum logic [3:0] {
		FLIU_SRC_X0 = 4'h0, FLIU_SRC_LA = 4'h1, FLIU_SRC_LB = 4'h2, FLIU_SRC_T0 = 4'h3,
		FLIU_SRC_LC = 4'h4, FLIU_SRC_X1 = 4'h5, FLIU_SRC_LD = 4'h6, FLIU_SRC_T1 = 4'h7,
		FLIU_SRC_LE = 4'h8, FLIU_SRC_SER = 4'h9, FLIU_SRC_LF = 4'ha, FLIU_SRC_LG = 4'hb,
		FLIU_SRC_LH = 4'hc
	} fliu_src_e;
	// Priority group of each source.
	function automatic logic [2:0] fliu_group(input logic [3:0] src);
		logic [2:0] g;
		g = 3'h0;
		unique case (src)
			4'h0, 4'h1, 4'h2: g = 3'h0;
			4'h3, 4'h4: g = 3'h1;
			4'h5, 4'h6: g = 3'h2;
			4'h7, 4'h8: g = 3'h3;
			4'h9, 4'ha: g = 3'h4;
			default: g = 3'h5;
		endcase
		return g;
	endfunction
	// Vector address of each source.
	function automatic logic [15:0] fliu_vector(input logic [3:0] src);
		logic [15:0] v;
		v = 16'h0000;
		unique case (src)
			4'h0: v = 16'h0003;
			4'h1: v = 16'h0083;
			4'h2: v = 16'h0043;
			4'h3: v = 16'h000b;
			4'h4: v = 16'h004b;
			4'h5: v = 16'h0013;
			4'h6: v = 16'h0053;
			4'h7: v = 16'h001b;
			4'h8: v = 16'h005b;
			4'h9: v = 16'h0023;
			4'ha: v = 16'h0063;
			4'hb: v = 16'h002b;
			default: v = 16'h006b;
		endcase
		return v;
	endfunction
endpackage

// >>> rtl/fliu_pin_detect.sv
// Purpose: Synchronise one external pin and find falling edges per machine cycle.
// Assumes: Pin is asynchronous; mcyc_en is a one-clock pulse.
// Notes: Edge is seen only between two machine-cycle samples.
`timescale 1ns/1ps
`default_nettype none
module fliu_pin_detect (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic mcyc_en,
	input wire logic pin,
	output logic pin_low,
	output logic fall_pulse
);
	// ==========================================================
	// Two-stage synchroniser; first stage feeds only the second.
	logic meta_ff; // First stage.
	logic sync_ff; // Second stage.
	logic samp_ff; // Level at the previous machine cycle.
	// Synchroniser chain.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
		end else begin
			meta_ff <= pin;
			sync_ff <= meta_ff;
		end
	end
	// Sampling only once per machine cycle is why the driver must hold each level that long.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			samp_ff <= 1'b1;
		end else if (mcyc_en) begin
			samp_ff <= sync_ff;
		end
	end
	// A fall is high at the last sample and low now.
	assign fall_pulse = mcyc_en & samp_ff & ~sync_ff;
	assign pin_low = ~sync_ff;
endmodule
`default_nettype wire

// >>> rtl/fliu_arbiter.sv
// Purpose: Pick the highest-level request, ties by polling order.
// Assumes: Requests are already gated by their enables.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module fliu_arbiter (
	input wire logic [fliu_pkg::FLIU_NUM_SRC-1:0] req,
	input wire logic [5:0] prio_low,
	input wire logic [5:0] prio_high,
	output logic win_valid,
	output logic [3:0] win_src,
	output logic [1:0] win_lvl
);
	import fliu_pkg::*;
	// ==========================================================
	// One pass over sources in polling order, keeping the highest level seen.
	always_comb begin
		logic [2:0] g;
		logic [1:0] lv;
		// Loop temporaries start defined so no latch is inferred for them.
		g = 3'h0;
		lv = 2'h0;
		win_valid = 1'b0;
		win_src = 4'h0;
		win_lvl = 2'h0;
		for (int i = 0; i < FLIU_NUM_SRC; i++) begin
			g = fliu_group(4'(i));
			lv = {prio_high[g], prio_low[g]};
			// Strictly higher level replaces; equal keeps the earlier source.
			if (req[i] && (!win_valid || lv > win_lvl)) begin
				win_valid = 1'b1;
				win_src = 4'(i);
				win_lvl = lv;
			end
		end
	end
endmodule
`default_nettype wire

// >>> verification/fliu_periph_model.sv
// Purpose: Peripheral logic model that raises the eight level requests.
// Assumes: Same clock as the unit; events and service writes come from the bench.
// Notes: A request stays high until service code writes to the peripheral.
`timescale 1ns/1ps
`default_nettype none
module fliu_periph_model (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [7:0] raise,
	input wire logic [7:0] sfr_clear,
	output logic [7:0] lvl_irq
);
	// ==========================================================
	// Request hold: a line drops only on a service write, and a clear wins over a raise in the same cycle.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			lvl_irq <= 8'h00;
		end else begin
			lvl_irq <= (lvl_irq | raise) & ~sfr_clear;
		end
	end
endmodule
`default_nettype wire

// >>> verification/four_level_interrupt_unit_tb_top.sv
// Purpose: Self-checking bench for the four level interrupt unit.
// Assumes: 200 MHz clock, register port with read data one cycle later.
// Notes: One row per trigger kind, then ties, preemption and masking by hand.
`timescale 1ns/1ps
`default_nettype none
module four_level_interrupt_unit_tb_top;
	import fliu_pkg::*;
	// ==========================================================
	// One row: trigger kind, enables, expected vector, request after return.
	typedef struct packed {
		logic [3:0] kind; // 0-7 level line, 8/9 timers, a/d serial, b/c pins.
		logic [7:0] pe;
		logic [7:0] xe;
		logic [15:0] vec;
		logic again;
	} fliu_row_s;
	logic clk_sys, nrst, wr, rd, p0, p1, t0, t1, tx, rx, ack, ret, req;
	logic [7:0] addr, wdata, rdata, raise, clr, lvl;
	logic [15:0] vec;
	int n_fail, num_checks;
	fliu_row_s rows [14] = '{'{4'h0, 8'h80, 8'h01, 16'h0083, 1'b1},
		'{4'h1, 8'h80, 8'h02, 16'h0043, 1'b1}, '{4'h2, 8'h80, 8'h04, 16'h004b, 1'b1},
		'{4'h3, 8'h80, 8'h08, 16'h0053, 1'b1}, '{4'h4, 8'h80, 8'h10, 16'h005b, 1'b1},
		'{4'h5, 8'h80, 8'h20, 16'h0063, 1'b1}, '{4'h6, 8'h80, 8'h40, 16'h002b, 1'b1},
		'{4'h7, 8'h80, 8'h80, 16'h006b, 1'b1}, '{4'h8, 8'h82, 8'h00, 16'h000b, 1'b0},
		'{4'h9, 8'h88, 8'h00, 16'h001b, 1'b0}, '{4'ha, 8'h90, 8'h00, 16'h0023, 1'b1},
		'{4'hb, 8'h81, 8'h00, 16'h0003, 1'b0}, '{4'hc, 8'h84, 8'h00, 16'h0013, 1'b0},
		'{4'hd, 8'h90, 8'h00, 16'h0023, 1'b1}};
	fliu_top fliu_top_i (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .ext_pin_zero(p0), .ext_pin_one(p1),
		.timer_zero_ovf(t0), .timer_one_ovf(t1), .serial_tx_done_flag(tx),
		.serial_rx_done_flag(rx), .level_irq_a(lvl[0]), .level_irq_b(lvl[1]),
		.level_irq_c(lvl[2]), .level_irq_d(lvl[3]), .level_irq_e(lvl[4]), .level_irq_f(lvl[5]),
		.level_irq_g(lvl[6]), .level_irq_h(lvl[7]), .vec_ack(ack), .ret_pulse(ret),
		.irq_req(req), .irq_vector(vec));
	fliu_periph_model fliu_periph_model_i (.clk_sys(clk_sys), .nrst(nrst), .raise(raise),
		.sfr_clear(clr), .lvl_irq(lvl));
	// ==========================================================
	// Shared tasks for comparisons, bus cycles and stimulus.
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	// Read data stand in the cycle after the strobe only, so it is checked there.
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		chk("rdata", {8'h00, rdata}, {8'h00, e});
	endtask
	task automatic trig(input logic [3:0] k, input logic on);
		@(posedge clk_sys);
		case (k)
			4'h8: t0 <= on;
			4'h9: t1 <= on;
			4'ha: tx <= on;
			4'hd: rx <= on;
			4'hb: p0 <= !on;
			4'hc: p1 <= !on;
			default: if (on) raise[k[2:0]] <= 1'b1; else clr[k[2:0]] <= 1'b1;
		endcase
		@(posedge clk_sys);
		t0 <= 1'b0;
		t1 <= 1'b0;
		raise <= 8'h00;
		clr <= 8'h00;
	endtask
	// Bounded wait: pin edges take up to one machine cycle plus the synchroniser.
	task automatic wait_req();
		for (int i = 0; i < 40 && req !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
		end
	endtask
	task automatic cpu(input logic a, input logic r);
		@(posedge clk_sys);
		ack <= a;
		ret <= r;
		@(posedge clk_sys);
		ack <= 1'b0;
		ret <= 1'b0;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ==========================================================
	// Clock, watchdog and main sequence.
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		results();
	end
	initial begin
		{nrst, wr, rd, t0, t1, tx, rx, ack, ret} = 9'h000;
		{p0, p1} = 2'b11;
		{addr, wdata, raise, clr} = 32'h0;
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		for (int a = 0; a < 4; a++) rd_chk(a[7:0], 8'h00);
		wr_reg(8'h07, 8'hff);
		rd_chk(8'h07, 8'h00);
		wr_reg(FLIU_OFS_EN_PRIMARY, 8'hff);
		rd_chk(FLIU_OFS_EN_PRIMARY, 8'h9f);
		wr_reg(FLIU_OFS_PRIO_HIGH, 8'hff);
		rd_chk(FLIU_OFS_PRIO_HIGH, 8'h3f);
		wr_reg(FLIU_OFS_PRIO_HIGH, 8'h00);
		wr_reg(FLIU_OFS_EN_PRIMARY, 8'h00);
		wr_reg(FLIU_OFS_EXT_CTRL, 8'h05);
		rd_chk(FLIU_OFS_EXT_CTRL, 8'h05);
		foreach (rows[i]) begin
			wr_reg(FLIU_OFS_EN_PRIMARY, rows[i].pe);
			wr_reg(FLIU_OFS_EN_EXTRA, rows[i].xe);
			trig(rows[i].kind, 1'b1);
			wait_req();
			chk("vector", vec, rows[i].vec);
			cpu(1'b1, 1'b0);
			cpu(1'b0, 1'b1);
			repeat (4) @(posedge clk_sys);
			#1;
			chk("req again", {15'h0, req}, {15'h0, rows[i].again});
			trig(rows[i].kind, 1'b0);
			wr_reg(FLIU_OFS_EN_PRIMARY, 8'h00);
			repeat (30) @(posedge clk_sys);
		end
		// Two level lines at once: polling order first, then priority.
		wr_reg(FLIU_OFS_EN_PRIMARY, 8'h80);
		wr_reg(FLIU_OFS_EN_EXTRA, 8'h81);
		trig(4'h7, 1'b1);
		trig(4'h0, 1'b1);
		wait_req();
		// The first line raised is presented alone for two cycles; let the pair settle.
		repeat (2) @(posedge clk_sys);
		#1;
		chk("tie vector", vec, 16'h0083);
		wr_reg(FLIU_OFS_PRIO_LOW, 8'h20);
		wr_reg(FLIU_OFS_PRIO_HIGH, 8'h20);
		repeat (3) @(posedge clk_sys);
		#1;
		chk("top vector", vec, 16'h006b);
		cpu(1'b1, 1'b0);
		repeat (4) @(posedge clk_sys);
		#1;
		chk("lower waits", {15'h0, req}, 16'h0000);
		rd_chk(FLIU_OFS_STATUS, 8'h08);
		trig(4'h7, 1'b0);
		cpu(1'b0, 1'b1);
		wait_req();
		chk("after return", vec, 16'h0083);
		// Level mode on pin zero: the flag follows the pin and survives vectoring.
		wr_reg(FLIU_OFS_EXT_CTRL, 8'h00);
		wr_reg(FLIU_OFS_EN_EXTRA, 8'h00);
		wr_reg(FLIU_OFS_EN_PRIMARY, 8'h81);
		trig(4'hb, 1'b1);
		wait_req();
		chk("level pin vector", vec, 16'h0003);
		cpu(1'b1, 1'b0);
		cpu(1'b0, 1'b1);
		repeat (4) @(posedge clk_sys);
		#1;
		chk("level pin again", {15'h0, req}, 16'h0001);
		wr_reg(FLIU_OFS_EN_PRIMARY, 8'h00);
		repeat (3) @(posedge clk_sys);
		#1;
		chk("global off", {15'h0, req}, 16'h0000);
		results();
	end
endmodule
`default_nettype wire
